// File: shared/pwmcpg_pkg.sv
package pwmcpg_pkg;
   // word byte offsets on the avalon slave
   localparam logic [5:0] ADDR_MAIN = 6'h00;
   localparam logic [5:0] ADDR_LIMIT = 6'h04;
   localparam logic [5:0] ADDR_PHASE = 6'h08;
   localparam logic [5:0] ADDR_PROT = 6'h0C;
   localparam logic [5:0] ADDR_PERIOD = 6'h10;
   localparam logic [5:0] ADDR_MAXP = 6'h14;
   localparam logic [5:0] ADDR_DELAY = 6'h18;
   localparam logic [5:0] ADDR_MAXD = 6'h1C;
   localparam logic [5:0] ADDR_THRESH = 6'h20;
   // reset values
   localparam logic [7:0] MAIN_RST = 8'h00;
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam logic [7:0] PHASE_RST = 8'h00;
   localparam logic [7:0] PROT_RST = 8'h00;
   // main control field positions
   localparam int B_ODD_SEL = 7;
   localparam int B_EVEN_SEL = 6;
   localparam int B_DIV_LO = 4;
   localparam int B_SHIFT_EN = 3;
   localparam int B_STOP = 2;
   localparam int B_DT_EN = 1;
   localparam int B_RUN = 0;
   // limit/flag control field positions
   localparam int B_SHUT_FLAG = 7;
   localparam int B_ADJ_FLAG = 6;
   localparam int B_PHASE_SEL = 5;
   localparam int B_TCK_SEL = 4;
   localparam int B_PLIM_EN = 3;
   localparam int B_NEG_STOP = 2;
   localparam int B_ODD_LVL = 1;
   localparam int B_EVEN_LVL = 0;
   // phase detect control field positions
   localparam int B_NOPH_FLAG = 7;
   localparam int B_DELAY_LO = 4;
   localparam int B_SMALL_FLAG = 3;
   localparam int B_SW_ERR = 1;
   localparam int B_DLIM_EN = 0;
   // protection register: [1:0] software, [3:2] error one, [5:4] error three, [6] trigger enable
   localparam int B_TRIG_EN = 6;
   // protection responses
   typedef enum logic [1:0] {
      PROT_SHUT_NOW = 2'b00,
      PROT_SHUT_END = 2'b01,
      PROT_ADJ_SHUT = 2'b10,
      PROT_ADJ_ONLY = 2'b11
   } pwmcpg_prot_t;
endpackage

// File: logic/pwmcpg_core.sv
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/100ps
`default_nettype none
module pwmcpg_core
   import pwmcpg_pkg::*;
#(
   parameter int PW = 12, // period width
   parameter int DW = 11  // delay width
) (
   input wire logic i_mclk,
   input wire logic i_resetn,
   input wire logic [5:0] i_address,
   input wire logic i_read,
   input wire logic i_write,
   input wire logic [31:0] i_writedata,
   output logic [31:0] o_readdata,
   output logic o_waitrequest,
   input wire logic i_error_signal_one,
   input wire logic i_error_signal_three,
   input wire logic i_comparator0_output,
   input wire logic i_comparator1_output,
   input wire logic i_phase0,
   input wire logic i_phase1,
   input wire logic i_phase_width_valid, // one-cycle pulse: width measurement done
   input wire logic [7:0] i_phase_width,
   input wire logic i_no_phase_event,    // one-cycle pulse from the phase detector
   input wire logic i_period_min_reached, // period is below the minimum
   output logic [3:0] o_pwm,
   output logic [3:0] o_pwm_oe,
   output logic o_timer_clock_out,
   output logic o_phase_signal,
   output logic o_phase_detect_active,
   output logic o_dead_time_active,
   output logic o_auto_adjust_active,
   output logic o_counter_tick,
   output logic [PW-1:0] o_period_value,
   output logic [DW-1:0] o_delay_time_value
);
   logic [7:0] main_ctl; // main control
   logic [7:0] lim_ctl; // limit/flag control
   logic [7:0] ph_ctl; // phase detect control
   logic [7:0] prot_ctl; // protection settings
   logic [PW-1:0] period_value;
   logic [PW-1:0] maximum_period_value;
   logic [DW-1:0] delay_time_value;
   logic [DW-1:0] maximum_delay_value;
   logic [7:0] phase_width_threshold;
   logic ack; // one wait cycle then answer
   logic run_q; // run bit last cycle, for edges
   logic err1_q, err3_q, sw_err_q;
   logic [2:0] div_cnt;
   logic tick;
   logic [PW-1:0] cnt; // period counter
   logic period_end;
   logic [2:0] ph_wait;
   logic adjusting;
   logic [1:0] adj_mode; // setting of the event that started adjust
   logic shut_pending;
   logic shutdown;
   logic pwm_wave;
   logic bus_wr;
   logic run_rise;
   logic sw_event, e1_rise, e3_rise, neg_stop;
   logic next_adjust; // a new event asks for auto-adjust
   logic [1:0] ev_mode; // setting of the newest event
   logic ev; // any protection event this cycle

   function automatic logic [1:0] prot_of(input logic [7:0] p, input int sel);
      prot_of = p[sel*2 +: 2];
   endfunction

   assign bus_wr = i_write && ack;
   assign run_rise = main_ctl[B_RUN] && !run_q;
   // software trigger only counts when enabled
   assign sw_event = ph_ctl[B_SW_ERR] && !sw_err_q && prot_ctl[B_TRIG_EN];
   assign e1_rise = i_error_signal_one && !err1_q;
   assign e3_rise = i_error_signal_three && !err3_q;
   // falling error under setting 11 acts like the stop bit
   assign neg_stop = lim_ctl[B_NEG_STOP] &&
      ((err1_q && !i_error_signal_one && prot_of(prot_ctl, 1) == PROT_ADJ_ONLY) ||
       (err3_q && !i_error_signal_three && prot_of(prot_ctl, 2) == PROT_ADJ_ONLY));

   // avalon handshake: one wait state per access, so answers arrive on the second edge
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ack <= 1'b0;
      end else begin
         ack <= (i_read || i_write) && !ack;
      end
   end
   assign o_waitrequest = (i_read || i_write) && !ack;

   // read mux registered; unmapped reads return zero
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_readdata <= 32'h0000_0000;
      end else if (i_read && !ack) begin
         if (i_address == ADDR_MAIN) begin
            o_readdata <= {24'h00_0000, main_ctl};
         end else if (i_address == ADDR_LIMIT) begin
            o_readdata <= {24'h00_0000, lim_ctl};
         end else if (i_address == ADDR_PHASE) begin
            o_readdata <= {24'h00_0000, ph_ctl};
         end else if (i_address == ADDR_PROT) begin
            o_readdata <= {24'h00_0000, prot_ctl};
         end else if (i_address == ADDR_PERIOD) begin
            o_readdata <= {{(32-PW){1'b0}}, period_value};
         end else if (i_address == ADDR_MAXP) begin
            o_readdata <= {{(32-PW){1'b0}}, maximum_period_value};
         end else if (i_address == ADDR_DELAY) begin
            o_readdata <= {{(32-DW){1'b0}}, delay_time_value};
         end else if (i_address == ADDR_MAXD) begin
            o_readdata <= {{(32-DW){1'b0}}, maximum_delay_value};
         end else if (i_address == ADDR_THRESH) begin
            o_readdata <= {24'h00_0000, phase_width_threshold};
         end else begin
            o_readdata <= 32'h0000_0000;
         end
      end
   end

   // edge history for run and error inputs
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         run_q <= 1'b0;
         err1_q <= 1'b0;
         err3_q <= 1'b0;
         sw_err_q <= 1'b0;
      end else begin
         run_q <= main_ctl[B_RUN];
         err1_q <= i_error_signal_one;
         err3_q <= i_error_signal_three;
         sw_err_q <= ph_ctl[B_SW_ERR];
      end
   end

   // main control; selects cleared on pair conflict, stop bit cleared by hardware when adjust stops at period end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         main_ctl <= MAIN_RST;
      end else begin
         if (bus_wr && i_address == ADDR_MAIN) begin
            main_ctl <= i_writedata[7:0];
            // one output on the wave, other on software: force back to wave
            if (i_writedata[B_ODD_SEL] != i_writedata[B_EVEN_SEL]) begin
               main_ctl[B_ODD_SEL] <= 1'b0;
               main_ctl[B_EVEN_SEL] <= 1'b0;
            end
         end
         // falling error edge files a stop request; a one-cycle pulse alone would miss the period end
         if (neg_stop && adjusting) begin
            main_ctl[B_STOP] <= 1'b1;
         end
         // adjust stopped at period end: hardware clears the request
         if (adjusting && period_end && (main_ctl[B_STOP] || neg_stop)) begin
            main_ctl[B_STOP] <= 1'b0;
         end
         if (shutdown) begin
            main_ctl[B_RUN] <= 1'b0;
         end
      end
   end

   // limit control with hardware-set flags; set wins over clear
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         lim_ctl <= LIMIT_RST;
      end else begin
         if (bus_wr && i_address == ADDR_LIMIT) begin
            lim_ctl[5:0] <= i_writedata[5:0];
            // flags clear only: writing 1 keeps old value
            lim_ctl[B_SHUT_FLAG] <= lim_ctl[B_SHUT_FLAG] & i_writedata[B_SHUT_FLAG];
            lim_ctl[B_ADJ_FLAG] <= lim_ctl[B_ADJ_FLAG] & i_writedata[B_ADJ_FLAG];
         end
         if (run_rise) begin
            lim_ctl[B_ADJ_FLAG] <= 1'b0;
         end
         if (shutdown) begin
            lim_ctl[B_SHUT_FLAG] <= 1'b1;
         end
         if (!adjusting && next_adjust) begin
            lim_ctl[B_ADJ_FLAG] <= 1'b1;
         end
      end
   end

   // phase detect control with clear-only flags
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ph_ctl <= PHASE_RST;
      end else begin
         if (bus_wr && i_address == ADDR_PHASE) begin
            ph_ctl[6:4] <= i_writedata[6:4];
            ph_ctl[2:0] <= i_writedata[2:0]; // reserved bit 2 kept as written
            ph_ctl[B_NOPH_FLAG] <= ph_ctl[B_NOPH_FLAG] & i_writedata[B_NOPH_FLAG];
            ph_ctl[B_SMALL_FLAG] <= ph_ctl[B_SMALL_FLAG] & i_writedata[B_SMALL_FLAG];
         end
         if (o_phase_detect_active && i_no_phase_event) begin
            ph_ctl[B_NOPH_FLAG] <= 1'b1;
         end
         if (o_phase_detect_active && i_phase_width_valid && i_phase_width < phase_width_threshold) begin
            ph_ctl[B_SMALL_FLAG] <= 1'b1;
         end
      end
   end

   // protection settings and value registers with write limits
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         prot_ctl <= PROT_RST;
         period_value <= '0;
         maximum_period_value <= '0;
         delay_time_value <= '0;
         maximum_delay_value <= '0;
         phase_width_threshold <= 8'h00;
      end else if (bus_wr) begin
         if (i_address == ADDR_PROT && !adjusting && !shut_pending) begin
            prot_ctl <= {1'b0, i_writedata[6:0]};
         end else if (i_address == ADDR_PERIOD) begin
            // oversize write dropped; old value stays even if above limit
            if (!lim_ctl[B_PLIM_EN] || i_writedata[PW-1:0] <= maximum_period_value) begin
               period_value <= i_writedata[PW-1:0];
            end
         end else if (i_address == ADDR_MAXP) begin
            maximum_period_value <= i_writedata[PW-1:0];
         end else if (i_address == ADDR_DELAY) begin
            if (!ph_ctl[B_DLIM_EN] || i_writedata[DW-1:0] <= maximum_delay_value) begin
               delay_time_value <= i_writedata[DW-1:0];
            end
         end else if (i_address == ADDR_MAXD) begin
            maximum_delay_value <= i_writedata[DW-1:0];
         end else if (i_address == ADDR_THRESH) begin
            phase_width_threshold <= i_writedata[7:0];
         end
      end
   end

   // counter clock prescaler: 1, 2, 4 or 8 input clocks per tick
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         div_cnt <= 3'h0;
      end else if (!main_ctl[B_RUN] || tick) begin
         div_cnt <= 3'h0;
      end else begin
         div_cnt <= div_cnt + 3'h1;
      end
   end
   assign tick = main_ctl[B_RUN] &&
      (div_cnt == ((3'h1 << main_ctl[B_DIV_LO +: 2]) - 3'h1));
   assign period_end = tick && (cnt >= period_value);

   // period counter: zero on run rise, frozen while stopped
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt <= '0;
      end else if (run_rise) begin
         cnt <= '0;
      end else if (tick) begin
         cnt <= period_end ? '0 : cnt + 1'b1;
      end
   end

   // phase detect start delay in whole periods
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         ph_wait <= 3'h0;
      end else if (!main_ctl[B_RUN]) begin
         ph_wait <= 3'h0;
      end else if (period_end && ph_wait != ph_ctl[B_DELAY_LO +: 3]) begin
         ph_wait <= ph_wait + 3'h1;
      end
   end
   assign o_phase_detect_active = main_ctl[B_RUN] && !run_rise &&
      (ph_wait == ph_ctl[B_DELAY_LO +: 3]);

   // protection: new events by setting; adjust or shut down
   always_comb begin
      ev = 1'b0;
      ev_mode = PROT_SHUT_NOW;
      if (sw_event) begin
         ev = 1'b1;
         ev_mode = prot_of(prot_ctl, 0);
      end else if (e1_rise) begin
         ev = 1'b1;
         ev_mode = prot_of(prot_ctl, 1);
      end else if (e3_rise) begin
         ev = 1'b1;
         ev_mode = prot_of(prot_ctl, 2);
      end
      next_adjust = main_ctl[B_RUN] && ev && ev_mode[1];
   end

   // adjust state: ends by stop bit or by minimum (only under 1x); minimum under 10 then shuts down at period end
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         adjusting <= 1'b0;
         adj_mode <= PROT_SHUT_NOW;
         shut_pending <= 1'b0;
      end else begin
         if (!main_ctl[B_RUN]) begin
            adjusting <= 1'b0;
            shut_pending <= 1'b0;
         end else begin
            if (next_adjust && !adjusting) begin
               adjusting <= 1'b1;
               adj_mode <= ev_mode;
            end else if (adjusting && period_end &&
                         (main_ctl[B_STOP] || neg_stop)) begin
               adjusting <= 1'b0;
            end else if (adjusting && period_end && i_period_min_reached) begin
               adjusting <= 1'b0;
               shut_pending <= (adj_mode == PROT_ADJ_SHUT);
            end
            if (ev && ev_mode == PROT_SHUT_END) begin
               shut_pending <= 1'b1;
            end
         end
      end
   end
   assign shutdown = main_ctl[B_RUN] &&
      ((ev && ev_mode == PROT_SHUT_NOW) || (shut_pending && period_end));
   assign o_auto_adjust_active = adjusting;

   // output mux and pair protection
   assign pwm_wave = cnt < (period_value >> 1);
   assign o_dead_time_active = main_ctl[B_DT_EN] && main_ctl[B_RUN];
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_pwm <= 4'h0;
         o_pwm_oe <= 4'h0;
      end else if (main_ctl[B_ODD_SEL] && main_ctl[B_EVEN_SEL]) begin
         o_pwm_oe <= 4'hF;
         if (lim_ctl[B_ODD_LVL] && lim_ctl[B_EVEN_LVL]) begin
            o_pwm <= 4'h0;
         end else begin
            o_pwm <= {2{lim_ctl[B_ODD_LVL], lim_ctl[B_EVEN_LVL]}};
         end
      end else if (!main_ctl[B_RUN]) begin
         o_pwm <= 4'h0;
         o_pwm_oe <= 4'h0;
      end else begin
         o_pwm_oe <= 4'hF;
         // shifted pair uses half-period offset of the same wave
         if (main_ctl[B_SHIFT_EN]) begin
            o_pwm[3:2] <= {pwm_wave, !pwm_wave};
         end else begin
            o_pwm[3:2] <= {!pwm_wave, pwm_wave};
         end
         o_pwm[1:0] <= {!pwm_wave, pwm_wave};
      end
   end

   assign o_timer_clock_out = lim_ctl[B_TCK_SEL] ? i_comparator1_output : i_comparator0_output;
   assign o_phase_signal = lim_ctl[B_PHASE_SEL] ? i_phase1 : i_phase0;
   assign o_counter_tick = tick;
   assign o_period_value = period_value;
   assign o_delay_time_value = delay_time_value;

   a_run_rise_zero: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      run_rise |=> cnt == '0 || tick) else $error("counter not zeroed on run");
   a_stop_freeze: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      !main_ctl[B_RUN] && run_q == main_ctl[B_RUN] |=> $stable(cnt)) else $error("counter moved while stopped");
   a_float_stop: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      !main_ctl[B_RUN] && !(main_ctl[B_ODD_SEL] && main_ctl[B_EVEN_SEL]) |=> o_pwm_oe == 4'h0)
      else $error("outputs driven while stopped");
   a_pair_both_low: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      main_ctl[B_ODD_SEL] && main_ctl[B_EVEN_SEL] && lim_ctl[B_ODD_LVL] && lim_ctl[B_EVEN_LVL]
      |=> o_pwm == 4'h0) else $error("pair not forced low");
   a_period_limit: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      bus_wr && i_address == ADDR_PERIOD && lim_ctl[B_PLIM_EN] && i_writedata[PW-1:0] > maximum_period_value
      |=> $stable(period_value)) else $error("oversize period accepted");
   a_delay_limit: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      bus_wr && i_address == ADDR_DELAY && ph_ctl[B_DLIM_EN] && i_writedata[DW-1:0] > maximum_delay_value
      |=> $stable(delay_time_value)) else $error("oversize delay accepted");
   a_shut_flag: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      shutdown |=> lim_ctl[B_SHUT_FLAG] && !main_ctl[B_RUN]) else $error("shutdown flag lost");
   a_dead_time: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      o_dead_time_active |-> main_ctl[B_RUN] && main_ctl[B_DT_EN]) else $error("dead time without run");
   a_sel_conflict: assert property (@(posedge i_mclk) disable iff (!i_resetn)
      bus_wr && i_address == ADDR_MAIN && i_writedata[B_ODD_SEL] != i_writedata[B_EVEN_SEL]
      |=> !main_ctl[B_ODD_SEL] && !main_ctl[B_EVEN_SEL]) else $error("select conflict stored");
   c_run: cover property (@(posedge i_mclk) run_rise);
   c_adjust: cover property (@(posedge i_mclk) adjusting && period_end);
   c_shutdown: cover property (@(posedge i_mclk) shutdown);
   c_phase: cover property (@(posedge i_mclk) o_phase_detect_active && ph_ctl[6:4] != 3'h0);
endmodule
`default_nettype wire

// File: tb/pwmcpg_gate_model.sv
`timescale 1ns/100ps
`default_nettype none
// gate driver inputs of both half-bridge legs
module pwmcpg_gate_model (
   input wire logic [3:0] i_pwm,
   input wire logic [3:0] i_pwm_oe,
   output logic [3:0] o_gate,
   output logic [1:0] o_shoot
);
   // an undriven line falls to the driver's pull-down, so a floating core never turns a switch on
   assign o_gate = i_pwm & i_pwm_oe;
   // both switches of one leg on together would short the supply
   assign o_shoot = {o_gate[2] & o_gate[3], o_gate[0] & o_gate[1]};
endmodule
`default_nettype wire

// File: tb/pwm_control_and_phase_guard_bench.sv
`timescale 1ns/100ps
`default_nettype none
module pwm_control_and_phase_guard_bench;
   import pwmcpg_pkg::*;
   logic i_mclk, i_resetn, i_read, i_write, o_waitrequest; // bus side
   logic [5:0] i_address;
   logic [31:0] i_writedata, o_readdata, rd_seen, r;
   logic e1, e3, c0, c1, p0, p1, pv, np, pmin, tck, phs, pda, dta, aaa, tick; // side inputs and status
   logic [7:0] pw;
   logic [3:0] pwm, oe, gate;
   logic [1:0] shoot;
   logic [11:0] per;
   logic [10:0] dly;
   int failures = 0, n_checks = 0, cyc = 0, gap;
   integer seed = 32'h230814aa;
   logic [31:0] exp_q[$]; // expected read data, oldest first
   logic [11:0] vals[5] = '{12'h1F4, 12'h400, 12'h3F2, 12'h3D4, 12'h3F2};
   logic [11:0] exps[5] = '{12'h1F4, 12'h400, 12'h400, 12'h3D4, 12'h3D4};
   event rd_ev;

   pwmcpg_core dut (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_address(i_address), .i_read(i_read),
      .i_write(i_write), .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
      .i_error_signal_one(e1), .i_error_signal_three(e3), .i_comparator0_output(c0),
      .i_comparator1_output(c1), .i_phase0(p0), .i_phase1(p1), .i_phase_width_valid(pv),
      .i_phase_width(pw), .i_no_phase_event(np), .i_period_min_reached(pmin), .o_pwm(pwm), .o_pwm_oe(oe),
      .o_timer_clock_out(tck), .o_phase_signal(phs), .o_phase_detect_active(pda),
      .o_dead_time_active(dta), .o_auto_adjust_active(aaa), .o_counter_tick(tick),
      .o_period_value(per), .o_delay_time_value(dly));
   pwmcpg_gate_model gates (.i_pwm(pwm), .i_pwm_oe(oe), .o_gate(gate), .o_shoot(shoot));

   // free-running clock, 20 ns
   initial begin
      i_mclk = 0;
      forever #10 i_mclk = ~i_mclk;
   end

   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // one bus cycle; an idle edge first so no strobe is driven twice in one time step
   task automatic bus(logic [5:0] a, logic w, logic [31:0] d, logic [31:0] e);
      @(posedge i_mclk);
      i_address <= a;
      i_write <= w;
      i_read <= !w;
      i_writedata <= d;
      if (!w) exp_q.push_back(e);
      // waitrequest and read data are taken at the rising edge itself, before it updates them
      do begin
         @(posedge i_mclk);
      end while (o_waitrequest);
      rd_seen = o_readdata;
      i_write <= 0;
      i_read <= 0;
      if (!w) ->rd_ev;
   endtask

   task automatic wr(logic [5:0] a, logic [31:0] d);
      bus(a, 1, d, 0);
   endtask

   task automatic rd(logic [5:0] a, logic [31:0] e);
      bus(a, 0, 0, e);
   endtask

   function automatic logic [31:0] probe(int k);
      case (k)
         0: return 32'(oe);
         1: return 32'(per);
         2: return 32'(dly);
         3: return 32'(dta);
         default: return 32'(aaa);
      endcase
   endfunction

   // registered outputs follow a write within a few cycles; bounded wait then compare
   task automatic expect_out(string nm, int k, logic [31:0] e);
      // never look in the time step of the edge that launches the output
      @(negedge i_mclk);
      for (int i = 0; i < 8 && probe(k) !== e; i++) @(negedge i_mclk);
      check(nm, probe(k), e);
   endtask

   // read data watcher: each accepted read takes the oldest note
   initial begin
      forever begin
         @(rd_ev);
         check("readdata", rd_seen, exp_q.pop_front());
      end
   end

   // hang guard, far above the few thousand cycles the tests need
   always @(posedge i_mclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end

   initial begin
      i_resetn = 0;
      {i_read, i_write, i_address, i_writedata} = '0;
      {e1, e3, c0, c1, p0, p1, pv, np, pmin, pw} = '0;
      repeat (2) @(posedge i_mclk);
      i_resetn <= 1;
      rd(ADDR_MAIN, 32'(MAIN_RST));
      rd(ADDR_LIMIT, 32'(LIMIT_RST));
      rd(ADDR_PHASE, 32'(PHASE_RST));
      rd(6'h3C, 32'h0000_0000);
      // flags only clear from software; reserved bit 2 left at zero
      wr(ADDR_LIMIT, 32'h0000_00C0);
      rd(ADDR_LIMIT, 32'h0000_0000);
      wr(ADDR_PHASE, 32'h0000_0088);
      rd(ADDR_PHASE, 32'h0000_0000);
      // one select alone is forced back to the wave
      wr(ADDR_MAIN, 32'h0000_0080);
      rd(ADDR_MAIN, 32'h0000_0000);
      wr(ADDR_MAIN, 32'h0000_0040);
      rd(ADDR_MAIN, 32'h0000_0000);
      $display("test registers done");
      // stopped, both selects: software levels, both-high forced low
      for (int l = 0; l < 4; l++) begin
         wr(ADDR_LIMIT, 32'(l));
         wr(ADDR_MAIN, 32'h0000_00C0);
         expect_out("oe", 0, 32'h0000_000F);
         check("pwm", 32'(pwm), (l == 3) ? 32'h0 : 32'({l[1], l[0], l[1], l[0]}));
         check("shoot", 32'(shoot), 32'h0000_0000);
         check("gate", 32'(gate), (l == 3) ? 32'h0 : 32'({l[1], l[0], l[1], l[0]}));
      end
      wr(ADDR_MAIN, 32'h0000_0000);
      expect_out("oe", 0, 32'h0000_0000);
      check("gate", 32'(gate), 32'h0000_0000);
      $display("test levels done");
      // period then delay limit sequences
      for (int t = 0; t < 2; t++) begin
         wr(t ? ADDR_MAXD : ADDR_MAXP, 32'h0000_03E8);
         for (int s = 0; s < 5; s++) begin
            if (s == 2) wr(t ? ADDR_PHASE : ADDR_LIMIT, t ? 32'h0000_0001 : 32'h0000_0008);
            wr(t ? ADDR_DELAY : ADDR_PERIOD, 32'(vals[s]));
            expect_out("limited", 1 + t, 32'(exps[s]));
         end
         rd(t ? ADDR_DELAY : ADDR_PERIOD, 32'h0000_03D4);
         wr(t ? ADDR_PHASE : ADDR_LIMIT, 32'h0000_0000);
      end
      $display("test limits done");
      // running with dead time, each divider code
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_MAIN, 32'({k[1:0], k[0], 3'h3}));
         expect_out("deadtime", 3, 32'h0000_0001);
         expect_out("oe", 0, 32'h0000_000F);
         for (gap = 0; gap < 50 && tick !== 1'b1; gap++) @(negedge i_mclk);
         gap = 0;
         do begin
            @(negedge i_mclk);
            gap++;
         end while (tick !== 1'b1 && gap < 50);
         check("divider", 32'(gap), 32'(1 << k));
         check("complement", 32'({pwm[3] ^ pwm[2], pwm[1] ^ pwm[0]}), 32'h0000_0003);
         check("shifted", 32'(pwm[2] ^ pwm[0]), 32'(k[0]));
      end
      wr(ADDR_MAIN, 32'h0000_0001);
      expect_out("deadtime", 3, 32'h0000_0000);
      wr(ADDR_MAIN, 32'h0000_0000);
      expect_out("oe", 0, 32'h0000_0000);
      $display("test running done");
      // software error: ignored without trigger enable, shuts down at once under setting 00
      wr(ADDR_MAIN, 32'h0000_0001);
      wr(ADDR_PHASE, 32'h0000_0002);
      rd(ADDR_MAIN, 32'h0000_0001);
      wr(ADDR_PHASE, 32'h0000_0000);
      wr(ADDR_PROT, 32'h0000_0040);
      wr(ADDR_PHASE, 32'h0000_0002);
      rd(ADDR_MAIN, 32'h0000_0000);
      rd(ADDR_LIMIT, 32'h0000_0080);
      wr(ADDR_PHASE, 32'h0000_0000);
      wr(ADDR_PROT, 32'h0000_000C);
      // error one under setting 11: adjust, stopped by software then by the falling edge
      for (int m = 0; m < 2; m++) begin
         wr(ADDR_LIMIT, 32'(m << 2));
         wr(ADDR_MAIN, 32'h0000_0001);
         @(posedge i_mclk);
         e1 <= 1'b1;
         expect_out("adjusting", 4, 32'h0000_0001);
         rd(ADDR_LIMIT, 32'(m << 2) | 32'h0000_0040);
         @(posedge i_mclk);
         e1 <= 1'b0;
         if (m == 0) wr(ADDR_MAIN, 32'h0000_0005);
         for (gap = 0; gap < 2000 && aaa !== 1'b0; gap++) @(negedge i_mclk);
         check("adjust stop", 32'(aaa), 32'h0000_0000);
         rd(ADDR_MAIN, 32'h0000_0001);
         wr(ADDR_MAIN, 32'h0000_0000);
      end
      wr(ADDR_MAIN, 32'h0000_0001);
      rd(ADDR_LIMIT, 32'h0000_0004);
      wr(ADDR_MAIN, 32'h0000_0000);
      $display("test protection done");
      // phase detection after one period, then both detector flags
      wr(ADDR_THRESH, 32'h0000_0080);
      wr(ADDR_PHASE, 32'h0000_0010);
      wr(ADDR_MAIN, 32'h0000_0001);
      repeat (2) @(negedge i_mclk);
      check("phase wait", 32'(pda), 32'h0000_0000);
      for (gap = 0; gap < 2000 && pda !== 1'b1; gap++) @(negedge i_mclk);
      check("phase start", 32'(pda), 32'h0000_0001);
      check("phase delay", 32'(gap >= 900), 32'h0000_0001);
      @(posedge i_mclk);
      {pv, np} <= 2'b11;
      pw <= 8'h10;
      @(posedge i_mclk);
      {pv, np} <= 2'b00;
      rd(ADDR_PHASE, 32'h0000_0098);
      wr(ADDR_MAIN, 32'h0000_0000);
      $display("test phase done");
      // random comparator and phase levels through both selectors
      repeat (8) begin
         r = $random(seed);
         @(posedge i_mclk);
         {c0, c1, p0, p1} <= r[3:0];
         pw <= r[15:8];
         wr(ADDR_LIMIT, 32'({r[5:4], 4'h0}));
         @(negedge i_mclk);
         check("timer clock", 32'(tck), 32'(r[4] ? r[2] : r[3]));
         check("phase", 32'(phs), 32'(r[5] ? r[0] : r[1]));
      end
      $display("test selectors done");
      print_verdict();
   end
endmodule
`default_nettype wire
